// File: rtl/asw3_pkg.sv
package asw3_pkg;
    // register offsets on the plain register port (byte addresses)
    localparam logic [7:0] ASW3_OFF_STATUS = 8'h00;
    localparam logic [7:0] ASW3_OFF_IRQ_STAT = 8'h04;
    localparam logic [7:0] ASW3_OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] ASW3_OFF_P_OFFSET = 8'h0C;
    localparam logic [7:0] ASW3_OFF_T_OFFSET = 8'h10;
    localparam logic [7:0] ASW3_OFF_T_SPAN_MIN = 8'h14;
    localparam logic [7:0] ASW3_OFF_T_SPAN_MAX = 8'h18;
    localparam logic [7:0] ASW3_OFF_ADJ_STAT = 8'h1C;
    localparam logic [7:0] ASW3_OFF_LIMIT_BASE = 8'h20;
    localparam logic [7:0] ASW3_OFF_LIMIT_LAST = 8'h3C;
    localparam logic [7:0] ASW3_OFF_SENSOR_ID = 8'h40;
    localparam logic [7:0] ASW3_OFF_SENSOR_CAL = 8'h44;

    // limit registers: index = quantity * 2 + kind
    localparam int ASW3_NUM_QTY = 4;
    localparam int ASW3_LIM_WARN = 0;
    localparam int ASW3_LIM_ALARM = 1;
    localparam int ASW3_QTY_CONV_VOL = 0;
    localparam int ASW3_QTY_CONV_FLOW = 1;
    localparam int ASW3_QTY_BASE_VOL = 2;
    localparam int ASW3_QTY_BASE_FLOW = 3;

    // flag positions of the status display word
    localparam int ASW3_BIT_UNUSED = 15;
    localparam int ASW3_BIT_GEN_LOG = 11;
    localparam int ASW3_BIT_CAL_LOG = 10;
    localparam int ASW3_BIT_CONTACT2 = 9;
    localparam int ASW3_BIT_CONTACT1 = 8;
    localparam int ASW3_BIT_CONV_VOL_W = 7;
    localparam int ASW3_BIT_CONV_VOL_A = 6;
    localparam int ASW3_BIT_CONV_FLOW_W = 5;
    localparam int ASW3_BIT_CONV_FLOW_A = 4;
    localparam int ASW3_BIT_BASE_VOL_W = 3;
    localparam int ASW3_BIT_BASE_VOL_A = 2;
    localparam int ASW3_BIT_BASE_FLOW_W = 1;
    localparam int ASW3_BIT_BASE_FLOW_A = 0;

    // adjustment status bits
    localparam int ASW3_ADJ_REJECTED = 0;
    localparam int ASW3_ADJ_LOAD_BUSY = 1;

    // reset values
    localparam logic [15:0] ASW3_RST_WORD = 16'h0000;
    localparam logic [31:0] ASW3_RST_LIMIT = 32'hFFFF_FFFF;
    localparam logic [31:0] ASW3_RST_ZERO = 32'h0000_0000;

    // span factor fraction bits (signed fixed point)
    localparam int ASW3_SPAN_FRAC = 15;

    typedef enum logic [0:0] {
        ASW3_LD_IDLE,
        ASW3_LD_REQ
    } asw3_load_e;
endpackage

// File: rtl/asw3_thresh.sv
`timescale 1ns/100ps
module asw3_thresh
    import asw3_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic [W-1:0] value_i,     // measured quantity
    input wire logic [W-1:0] warn_lim_i,  // warning limit
    input wire logic [W-1:0] alarm_lim_i, // alarm limit
    output logic warn_o,                  // value above warning limit
    output logic alarm_o                  // value above alarm limit
);
    if (W < 2) begin : g_chk
        $error("asw3_thresh: W too small");
    end

    // strict compare: a value equal to the limit is not yet over it
    always_comb begin
        warn_o = value_i > warn_lim_i;
        alarm_o = value_i > alarm_lim_i;
    end
endmodule

// File: rtl/asw3_tcorr.sv
`timescale 1ns/100ps
module asw3_tcorr
    import asw3_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic signed [W-1:0] t_raw_i,    // measured temperature
    input wire logic signed [W-1:0] offset_i,   // common offset
    input wire logic signed [W-1:0] span_min_i, // span below zero
    input wire logic signed [W-1:0] span_max_i, // span from zero up
    output logic signed [W-1:0] t_corr_o        // corrected temperature
);
    logic signed [2*W-1:0] prod;
    logic signed [2*W-1:0] scaled;

    if (W <= ASW3_SPAN_FRAC) begin : g_chk
        $error("asw3_tcorr: W must exceed span fraction bits");
    end

    // sign of the raw reading picks the span segment
    always_comb begin
        prod = t_raw_i * ((t_raw_i < 0) ? span_min_i : span_max_i);
        scaled = prod >>> ASW3_SPAN_FRAC;
        // result wraps on overflow; limits keep readings far from it
        t_corr_o = t_raw_i + offset_i + scaled[W-1:0];
    end
endmodule

// File: rtl/asw3_status_word.sv
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module asw3_status_word
    import asw3_pkg::*;
#(
    parameter int VW = 32, // width of volume and flow values
    parameter int MW = 16  // width of pressure and temperature values
) (
    input wire logic clk_i,                           // 40 MHz clock
    input wire logic resetn_i,                        // async reset, active low
    input wire logic [7:0] addr_i,                    // register byte address
    input wire logic [31:0] wdata_i,                  // write data
    input wire logic we_i,                            // write strobe
    input wire logic re_i,                            // read strobe
    output logic [31:0] rdata_o,                      // read data, cycle after re_i
    output logic irq_o,                               // level interrupt
    input wire logic gen_log_full_i,                  // general log full and wrapping
    input wire logic cal_log_full_i,                  // calibration log full
    input wire logic [1:0] contact_closed_i,          // alarm contacts, 1 = closed
    input wire logic [VW-1:0] hourly_converted_volume_i, // hourly converted volume
    input wire logic [VW-1:0] converted_flow_rate_i,  // converted flow rate
    input wire logic [VW-1:0] hourly_base_volume_i,   // hourly base volume
    input wire logic [VW-1:0] base_flow_rate_i,       // base flow rate
    input wire logic cal_switch_i,                    // calibration switch held
    input wire logic signed [MW-1:0] pressure_raw_i,  // measured pressure
    input wire logic signed [MW-1:0] temp_raw_i,      // measured temperature
    output logic signed [MW-1:0] pressure_o,          // adjusted pressure
    output logic signed [MW-1:0] temp_o,              // adjusted temperature
    input wire logic housing_open_i,                  // housing open
    output logic sensor_req_o,                        // sensor data request
    input wire logic sensor_ack_i,                    // sensor data valid
    input wire logic [31:0] sensor_serial_i,          // sensor identity
    input wire logic [31:0] sensor_cal_i,             // sensor calibration word
    output logic [15:0] status_display_word_o         // status word, four hex digits
);
    if (VW > 32 || VW < 2 || MW > 32 || MW <= ASW3_SPAN_FRAC) begin : g_chk
        $error("asw3_status_word: unsupported widths");
    end

    ////////////////////////////////////////////////////////////////////////////
    // condition flags
    logic [VW-1:0] limit [2*ASW3_NUM_QTY];
    logic [VW-1:0] value [ASW3_NUM_QTY];
    logic [ASW3_NUM_QTY-1:0] cmp_warn;
    logic [ASW3_NUM_QTY-1:0] cmp_alarm;
    logic [15:0] status_q;
    logic [15:0] next_status;

    always_comb begin
        value[ASW3_QTY_CONV_VOL] = hourly_converted_volume_i;
        value[ASW3_QTY_CONV_FLOW] = converted_flow_rate_i;
        value[ASW3_QTY_BASE_VOL] = hourly_base_volume_i;
        value[ASW3_QTY_BASE_FLOW] = base_flow_rate_i;
    end

    for (genvar q = 0; q < ASW3_NUM_QTY; q++) begin : g_qty
        asw3_thresh #(.W(VW)) u_thresh (
            .value_i(value[q]),
            .warn_lim_i(limit[2*q+ASW3_LIM_WARN]),
            .alarm_lim_i(limit[2*q+ASW3_LIM_ALARM]),
            .warn_o(cmp_warn[q]),
            .alarm_o(cmp_alarm[q])
        );
    end

    // recomputed every cycle from the causes, so nothing latches
    always_comb begin
        next_status = ASW3_RST_WORD;
        next_status[ASW3_BIT_UNUSED] = 1'b0;
        next_status[ASW3_BIT_GEN_LOG] = gen_log_full_i;
        next_status[ASW3_BIT_CAL_LOG] = cal_log_full_i;
        next_status[ASW3_BIT_CONTACT2] = ~contact_closed_i[1];
        next_status[ASW3_BIT_CONTACT1] = ~contact_closed_i[0];
        next_status[ASW3_BIT_CONV_VOL_W] = cmp_warn[ASW3_QTY_CONV_VOL];
        next_status[ASW3_BIT_CONV_VOL_A] = cmp_alarm[ASW3_QTY_CONV_VOL];
        next_status[ASW3_BIT_CONV_FLOW_W] = cmp_warn[ASW3_QTY_CONV_FLOW];
        next_status[ASW3_BIT_CONV_FLOW_A] = cmp_alarm[ASW3_QTY_CONV_FLOW];
        next_status[ASW3_BIT_BASE_VOL_W] = cmp_warn[ASW3_QTY_BASE_VOL];
        next_status[ASW3_BIT_BASE_VOL_A] = cmp_alarm[ASW3_QTY_BASE_VOL];
        next_status[ASW3_BIT_BASE_FLOW_W] = cmp_warn[ASW3_QTY_BASE_FLOW];
        next_status[ASW3_BIT_BASE_FLOW_A] = cmp_alarm[ASW3_QTY_BASE_FLOW];
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_q <= ASW3_RST_WORD;
        end else begin
            status_q <= next_status;
        end
    end

    // bit 15 is the top of digit one, so each nibble weighs 8 4 2 1
    assign status_display_word_o = status_q;

    ////////////////////////////////////////////////////////////////////////////
    // adjustments, interrupt and register port
    logic [15:0] irq_stat;
    logic [15:0] irq_mask;
    logic signed [MW-1:0] p_offset;
    logic signed [MW-1:0] t_offset;
    logic signed [MW-1:0] span_min;
    logic signed [MW-1:0] span_max;
    logic rejected;
    logic [31:0] rdata;
    logic irq;
    logic [15:0] next_irq_stat;
    logic [15:0] next_irq_mask;
    logic signed [MW-1:0] next_p_offset;
    logic signed [MW-1:0] next_t_offset;
    logic signed [MW-1:0] next_span_min;
    logic signed [MW-1:0] next_span_max;
    logic next_rejected;
    logic [31:0] next_rdata;
    logic [VW-1:0] next_limit [2*ASW3_NUM_QTY];
    logic adj_wr;
    logic load_busy;
    logic [31:0] sensor_id;
    logic [31:0] sensor_cal;
    logic [7:0] lim_off;

    always_comb begin
        adj_wr = we_i && (addr_i == ASW3_OFF_P_OFFSET || addr_i == ASW3_OFF_T_OFFSET ||
                          addr_i == ASW3_OFF_T_SPAN_MIN || addr_i == ASW3_OFF_T_SPAN_MAX);
        lim_off = addr_i - ASW3_OFF_LIMIT_BASE;
        next_irq_mask = irq_mask;
        next_p_offset = p_offset;
        next_t_offset = t_offset;
        next_span_min = span_min;
        next_span_max = span_max;
        next_rejected = rejected;
        next_limit = limit;
        next_irq_stat = irq_stat;
        if (we_i && addr_i == ASW3_OFF_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~wdata_i[15:0];
        end
        // a rising flag sets its bit even in the clearing cycle
        next_irq_stat = next_irq_stat | (next_status & ~status_q);
        if (we_i && addr_i == ASW3_OFF_IRQ_MASK) begin
            next_irq_mask = wdata_i[15:0];
        end
        // the write is the confirmation: without the switch it is dropped
        if (adj_wr) begin
            next_rejected = !cal_switch_i;
        end
        if (adj_wr && cal_switch_i) begin
            if (addr_i == ASW3_OFF_P_OFFSET) begin
                next_p_offset = wdata_i[MW-1:0];
            end
            if (addr_i == ASW3_OFF_T_OFFSET) begin
                next_t_offset = wdata_i[MW-1:0];
            end
            if (addr_i == ASW3_OFF_T_SPAN_MIN) begin
                next_span_min = wdata_i[MW-1:0];
            end
            if (addr_i == ASW3_OFF_T_SPAN_MAX) begin
                next_span_max = wdata_i[MW-1:0];
            end
        end
        if (we_i && addr_i >= ASW3_OFF_LIMIT_BASE && addr_i <= ASW3_OFF_LIMIT_LAST && addr_i[1:0] == 2'b00) begin
            next_limit[lim_off[4:2]] = wdata_i[VW-1:0];
        end
        next_rdata = ASW3_RST_ZERO;
        if (re_i) begin
            unique case (addr_i)
                ASW3_OFF_STATUS: next_rdata[15:0] = status_q;
                ASW3_OFF_IRQ_STAT: next_rdata[15:0] = irq_stat;
                ASW3_OFF_IRQ_MASK: next_rdata[15:0] = irq_mask;
                ASW3_OFF_P_OFFSET: next_rdata[MW-1:0] = p_offset;
                ASW3_OFF_T_OFFSET: next_rdata[MW-1:0] = t_offset;
                ASW3_OFF_T_SPAN_MIN: next_rdata[MW-1:0] = span_min;
                ASW3_OFF_T_SPAN_MAX: next_rdata[MW-1:0] = span_max;
                ASW3_OFF_ADJ_STAT: begin
                    next_rdata[ASW3_ADJ_REJECTED] = rejected;
                    next_rdata[ASW3_ADJ_LOAD_BUSY] = load_busy;
                end
                ASW3_OFF_SENSOR_ID: next_rdata = sensor_id;
                ASW3_OFF_SENSOR_CAL: next_rdata = sensor_cal;
                default: begin
                    if (addr_i >= ASW3_OFF_LIMIT_BASE && addr_i <= ASW3_OFF_LIMIT_LAST && addr_i[1:0] == 2'b00) begin
                        next_rdata[VW-1:0] = limit[lim_off[4:2]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_stat <= ASW3_RST_WORD;
            irq_mask <= ASW3_RST_WORD;
            p_offset <= '0;
            t_offset <= '0;
            span_min <= '0;
            span_max <= '0;
            rejected <= 1'b0;
            rdata <= ASW3_RST_ZERO;
            irq <= 1'b0;
            for (int i = 0; i < 2*ASW3_NUM_QTY; i++) begin
                limit[i] <= ASW3_RST_LIMIT[VW-1:0];
            end
        end else begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            p_offset <= next_p_offset;
            t_offset <= next_t_offset;
            span_min <= next_span_min;
            span_max <= next_span_max;
            rejected <= next_rejected;
            rdata <= next_rdata;
            irq <= |(next_irq_stat & next_irq_mask);
            limit <= next_limit;
        end
    end

    assign rdata_o = rdata;
    assign irq_o = irq;

    ////////////////////////////////////////////////////////////////////////////
    // measurement correction
    logic signed [MW-1:0] t_corr;
    logic signed [MW-1:0] pressure;
    logic signed [MW-1:0] temp;

    asw3_tcorr #(.W(MW)) u_tcorr (
        .t_raw_i(temp_raw_i),
        .offset_i(t_offset),
        .span_min_i(span_min),
        .span_max_i(span_max),
        .t_corr_o(t_corr)
    );

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pressure <= '0;
            temp <= '0;
        end else begin
            pressure <= pressure_raw_i + p_offset;
            temp <= t_corr;
        end
    end

    assign pressure_o = pressure;
    assign temp_o = temp;

    ////////////////////////////////////////////////////////////////////////////
    // sensor data take-over after the housing closes
    asw3_load_e ld_state;
    asw3_load_e next_ld_state;
    logic housing_q;
    logic [31:0] next_sensor_id;
    logic [31:0] next_sensor_cal;

    always_comb begin
        next_ld_state = ld_state;
        next_sensor_id = sensor_id;
        next_sensor_cal = sensor_cal;
        unique case (ld_state)
            ASW3_LD_IDLE: begin
                if (housing_q && !housing_open_i) begin
                    next_ld_state = ASW3_LD_REQ;
                end
            end
            ASW3_LD_REQ: begin
                if (sensor_ack_i) begin
                    next_sensor_id = sensor_serial_i;
                    next_sensor_cal = sensor_cal_i;
                    next_ld_state = ASW3_LD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ld_state <= ASW3_LD_IDLE;
            housing_q <= 1'b0;
            sensor_id <= ASW3_RST_ZERO;
            sensor_cal <= ASW3_RST_ZERO;
        end else begin
            ld_state <= next_ld_state;
            housing_q <= housing_open_i;
            sensor_id <= next_sensor_id;
            sensor_cal <= next_sensor_cal;
        end
    end

    assign load_busy = (ld_state == ASW3_LD_REQ);
    assign sensor_req_o = load_busy;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_unused_bit_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
        status_display_word_o[ASW3_BIT_UNUSED] == 1'b0) else $error("bit F not zero");
    a_gen_log_mirror: assert property (@(posedge clk_i) disable iff (!resetn_i)
        gen_log_full_i [*2] |-> status_display_word_o[ASW3_BIT_GEN_LOG]) else $error("log flag missed");
    a_cal_log_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !cal_log_full_i |=> !status_display_word_o[ASW3_BIT_CAL_LOG]) else $error("cal log flag stuck");
    a_contact_open: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !contact_closed_i[1] |=> status_display_word_o[ASW3_BIT_CONTACT2]) else $error("contact flag missed");
    a_conv_vol_warn: assert property (@(posedge clk_i) disable iff (!resetn_i)
        hourly_converted_volume_i > limit[2*ASW3_QTY_CONV_VOL+ASW3_LIM_WARN]
        |=> status_display_word_o[ASW3_BIT_CONV_VOL_W]) else $error("volume warning missed");
    a_conv_flow_alarm: assert property (@(posedge clk_i) disable iff (!resetn_i)
        converted_flow_rate_i <= limit[2*ASW3_QTY_CONV_FLOW+ASW3_LIM_ALARM]
        |=> !status_display_word_o[ASW3_BIT_CONV_FLOW_A]) else $error("flow alarm false");
    a_base_vol_alarm: assert property (@(posedge clk_i) disable iff (!resetn_i)
        hourly_base_volume_i > limit[2*ASW3_QTY_BASE_VOL+ASW3_LIM_ALARM]
        |=> status_display_word_o[ASW3_BIT_BASE_VOL_A]) else $error("base volume alarm missed");
    a_base_flow_warn: assert property (@(posedge clk_i) disable iff (!resetn_i)
        base_flow_rate_i > limit[2*ASW3_QTY_BASE_FLOW+ASW3_LIM_WARN]
        |=> status_display_word_o[ASW3_BIT_BASE_FLOW_W]) else $error("base flow warning missed");
    a_pressure_shift: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $stable(p_offset) |=> pressure_o == MW'($past(pressure_raw_i) + $past(p_offset))) else $error("pressure offset");
    a_temp_plain_span: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (temp_raw_i >= 0 && span_max == 0) |=> temp_o == MW'($past(temp_raw_i) + $past(t_offset)))
        else $error("temperature correction");
    a_adjust_locked: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (we_i && addr_i == ASW3_OFF_P_OFFSET && !cal_switch_i) |=> $stable(p_offset) && rejected)
        else $error("adjustment taken without switch");
    a_close_loads: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (housing_q && !housing_open_i && !load_busy) |=> sensor_req_o) else $error("no sensor load");
endmodule

// File: rtl/asw3_dummy_unused.sv
`timescale 1ns/100ps

// File: dv/tb_asw3_status_word.sv
`timescale 1ns/100ps
module tb_asw3_status_word
    import asw3_pkg::*;
;
    logic clk_i, resetn_i, we_i, re_i, irq_o, gen_log_full_i, cal_log_full_i, cal_switch_i;
    logic housing_open_i, sensor_req_o, sensor_ack_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, sensor_serial_i, sensor_cal_i, rd_data;
    logic [1:0] contact_closed_i;
    logic [31:0] qty [4];
    logic signed [15:0] pressure_raw_i, temp_raw_i, pressure_o, temp_o;
    logic [15:0] status_display_word_o;
    int failures, checks, cycles;

    asw3_status_word i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o), .gen_log_full_i(gen_log_full_i),
        .cal_log_full_i(cal_log_full_i), .contact_closed_i(contact_closed_i),
        .hourly_converted_volume_i(qty[0]), .converted_flow_rate_i(qty[1]), .hourly_base_volume_i(qty[2]),
        .base_flow_rate_i(qty[3]), .cal_switch_i(cal_switch_i), .pressure_raw_i(pressure_raw_i),
        .temp_raw_i(temp_raw_i), .pressure_o(pressure_o), .temp_o(temp_o), .housing_open_i(housing_open_i),
        .sensor_req_o(sensor_req_o), .sensor_ack_i(sensor_ack_i), .sensor_serial_i(sensor_serial_i),
        .sensor_cal_i(sensor_cal_i), .status_display_word_o(status_display_word_o));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // the whole run needs well under a thousand cycles; the ceiling only catches hangs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({16'h0000, status_display_word_o}, 32'h0000_0000);
        rd(ASW3_OFF_LIMIT_BASE, rd_data);
        chk(rd_data, ASW3_RST_LIMIT);
        rd(8'h50, rd_data);
        chk(rd_data, 32'h0000_0000);
    endtask

    // strict compare: equal to the warning limit must not raise the flag
    task automatic t_thresholds();
        logic [31:0] vals [3];
        logic [15:0] exp;
        vals = '{32'h0000_0064, 32'h0000_0096, 32'h0000_00C9};
        for (int q = 0; q < 4; q++) begin
            wr(ASW3_OFF_LIMIT_BASE + 8'(q * 8), 32'h0000_0064);
            wr(ASW3_OFF_LIMIT_BASE + 8'(q * 8 + 4), 32'h0000_00C8);
            for (int v = 0; v < 3; v++) begin
                @(posedge clk_i);
                qty[q] <= vals[v];
                settle();
                exp = 16'h0000;
                exp[7 - 2 * q] = (v > 0);
                exp[6 - 2 * q] = (v > 1);
                chk({16'h0000, status_display_word_o}, {16'h0000, exp});
                rd(ASW3_OFF_STATUS, rd_data);
                chk(rd_data, {16'h0000, exp});
            end
            @(posedge clk_i);
            qty[q] <= 32'h0000_0000;
        end
        settle();
        chk({16'h0000, status_display_word_o}, 32'h0000_0000);
    endtask

    task automatic drive_flags(input logic g, input logic c, input logic [1:0] k, input logic [15:0] exp);
        @(posedge clk_i);
        gen_log_full_i <= g;
        cal_log_full_i <= c;
        contact_closed_i <= k;
        settle();
        chk({16'h0000, status_display_word_o}, {16'h0000, exp});
    endtask

    task automatic t_logs_contacts();
        drive_flags(1'b1, 1'b0, 2'b11, 16'h0800);
        drive_flags(1'b0, 1'b1, 2'b11, 16'h0400);
        drive_flags(1'b0, 1'b0, 2'b10, 16'h0100);
        drive_flags(1'b0, 1'b0, 2'b01, 16'h0200);
        drive_flags(1'b1, 1'b1, 2'b00, 16'h0F00);
        wr(ASW3_OFF_STATUS, 32'hFFFF_FFFF);
        settle();
        chk({16'h0000, status_display_word_o}, 32'h0000_0F00);
        drive_flags(1'b0, 1'b0, 2'b11, 16'h0000);
    endtask

    task automatic t_irq();
        wr(ASW3_OFF_IRQ_STAT, 32'h0000_FFFF);
        wr(ASW3_OFF_IRQ_MASK, 32'h0000_0800);
        settle();
        chk({31'd0, irq_o}, 32'h0000_0000);
        drive_flags(1'b0, 1'b1, 2'b11, 16'h0400);
        chk({31'd0, irq_o}, 32'h0000_0000);
        rd(ASW3_OFF_IRQ_STAT, rd_data);
        chk(rd_data, 32'h0000_0400);
        drive_flags(1'b1, 1'b1, 2'b11, 16'h0C00);
        chk({31'd0, irq_o}, 32'h0000_0001);
        wr(ASW3_OFF_IRQ_STAT, 32'h0000_0800);
        settle();
        chk({31'd0, irq_o}, 32'h0000_0000);
        drive_flags(1'b0, 1'b0, 2'b11, 16'h0000);
    endtask

    task automatic t_adjust();
        @(posedge clk_i);
        pressure_raw_i <= 16'h0064;
        temp_raw_i <= 16'hFFF8;
        cal_switch_i <= 1'b0;
        wr(ASW3_OFF_P_OFFSET, 32'h0000_0005);
        settle();
        chk({16'h0000, pressure_o}, 32'h0000_0064);
        rd(ASW3_OFF_ADJ_STAT, rd_data);
        chk(rd_data, 32'h0000_0001);
        @(posedge clk_i);
        cal_switch_i <= 1'b1;
        wr(ASW3_OFF_P_OFFSET, 32'h0000_0005);
        wr(ASW3_OFF_T_OFFSET, 32'h0000_0003);
        wr(ASW3_OFF_T_SPAN_MIN, 32'h0000_4000);
        wr(ASW3_OFF_T_SPAN_MAX, 32'h0000_2000);
        settle();
        chk({16'h0000, pressure_o}, 32'h0000_0069);
        rd(ASW3_OFF_ADJ_STAT, rd_data);
        chk(rd_data, 32'h0000_0000);
        chk({16'h0000, temp_o}, 32'h0000_FFF7);
        @(posedge clk_i);
        temp_raw_i <= 16'h0008;
        pressure_raw_i <= 16'hFFF0;
        cal_switch_i <= 1'b0;
        settle();
        chk({16'h0000, temp_o}, 32'h0000_000D);
        chk({16'h0000, pressure_o}, 32'h0000_FFF5);
    endtask

    // the ack is held off a few cycles so a design that ignores the handshake shows it
    task automatic t_sensor();
        int n;
        @(posedge clk_i);
        housing_open_i <= 1'b1;
        settle();
        @(posedge clk_i);
        housing_open_i <= 1'b0;
        n = 0;
        while (sensor_req_o !== 1'b1 && n < 10) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'd0, sensor_req_o}, 32'h0000_0001);
        // the busy bit must show while the load waits for its ack
        rd(ASW3_OFF_ADJ_STAT, rd_data);
        chk(rd_data, 32'h0000_0002);
        repeat (3) @(posedge clk_i);
        sensor_serial_i <= 32'h1234_5678;
        sensor_cal_i <= 32'h0000_ABCD;
        sensor_ack_i <= 1'b1;
        @(posedge clk_i);
        sensor_ack_i <= 1'b0;
        settle();
        chk({31'd0, sensor_req_o}, 32'h0000_0000);
        rd(ASW3_OFF_SENSOR_ID, rd_data);
        chk(rd_data, 32'h1234_5678);
        rd(ASW3_OFF_SENSOR_CAL, rd_data);
        chk(rd_data, 32'h0000_ABCD);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        checks = 0;
        cycles = 0;
        resetn_i = 1'b0;
        {we_i, re_i, gen_log_full_i, cal_log_full_i, cal_switch_i, housing_open_i, sensor_ack_i} = '0;
        addr_i = 8'h00;
        wdata_i = 32'h0000_0000;
        contact_closed_i = 2'b11;
        qty = '{default: 32'h0000_0000};
        pressure_raw_i = 16'h0000;
        temp_raw_i = 16'h0000;
        sensor_serial_i = 32'h0000_0000;
        sensor_cal_i = 32'h0000_0000;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        settle();
        t_reset();
        t_thresholds();
        t_logs_contacts();
        t_irq();
        t_adjust();
        t_sensor();
        results();
    end
endmodule
